// file: verilog/ssf_top.sv
// serial channel status flags with register port and engine event inputs
// How it works
// - empty flag set when tx off or loaded
// - empty flag cleared by zero after one read
// - full flag set on clean received word
// - full clears only by read-write; rx off keeps
// - overrun set on word while still full
// - framing set on zero first stop bit
// - parity flag set on parity check fail
// - writing one never sets clearable flags
// - complete set tx off or last bit empty
// - complete clears with the empty flag clear
// - received multiprocessor bit captured, held when off
// - transmit multiprocessor bit sent from bit zero
// - filter drops zero-mpb frames, clears on one
// - enables permit transmission and reception
//
// Chosen here: the register offsets and the strobed register port.
module ssf_top (
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // transmit engine events
  input wire logic tx_load,
  input wire logic tx_last_bit,
  // receive engine events
  input wire logic rx_done,
  input wire logic rx_stop_bit,
  input wire logic rx_parity_fail,
  input wire logic rx_mpb_in,
  // to the engines
  output logic tx_on_bit,
  output logic rx_enable_bit,
  output logic tx_multiproc_bit,
  output logic rx_store
);
  import ssf_pkg::*;

  // all registered state of the block
  typedef struct packed {
    logic [7:0] status;
    logic [2:0] control;
    logic [7:0] rdata;
    logic store;
  } ssf_top_type;

  ssf_top_type cur;
  ssf_top_type next_cur;
  logic rst_n; // synchronised reset
  logic [ssf_nclr-1:0] clr_flags; // current clearable flags
  logic [ssf_nclr-1:0] clr_set; // set events this cycle
  logic [ssf_nclr-1:0] clr_wbits; // written values per flag
  logic [ssf_nclr-1:0] clr_ok; // clear allowed this cycle
  logic st_wr; // write to status register
  logic st_rd; // read of status register
  logic ct_wr; // write to control register
  logic rx_active; // reception permitted
  logic tx_active; // transmission permitted
  logic rx_keep; // frame not discarded by filter
  logic rx_good; // clean frame accepted
  logic ev_tdempty; // empty flag set event
  logic ev_txdone; // complete flag set event

  ssf_reset_sync u_rst (
    .mclk(mclk),
    .rstn(rstn),
    .rst_sync_n(rst_n)
  );

  // address decode
  always_comb begin
    st_wr = 1'b0;
    st_rd = 1'b0;
    ct_wr = 1'b0;
    if (reg_addr == ssf_addr_status) begin
      st_wr = reg_wr;
      st_rd = reg_rd;
    end else if (reg_addr == ssf_addr_control) begin
      ct_wr = reg_wr;
    end
  end

  // engine qualifiers
  always_comb begin
    tx_active = cur.control[ssf_bit_txon];
    rx_active = cur.control[ssf_bit_rxon];
    // filtered frames with mpb 0 are skipped, but still set parity and load the received mpb
    rx_keep = ~cur.control[ssf_bit_filter] | rx_mpb_in;
    rx_good = rx_done & rx_active & rx_keep & rx_stop_bit & ~rx_parity_fail;
    // tx off forces empty; a load also empties the holding register
    ev_tdempty = ~tx_active | (tx_load & tx_active);
    // last bit out with nothing waiting means the line goes idle
    ev_txdone = ~tx_active
      | (tx_active & tx_last_bit & cur.status[ssf_bit_tdempty]);
  end

  // gather clearable flags into one vector for the arm tracker
  always_comb begin
    clr_flags[ssf_ci_tdempty] = cur.status[ssf_bit_tdempty];
    clr_flags[ssf_ci_rxfull] = cur.status[ssf_bit_rxfull];
    clr_flags[ssf_ci_overrun] = cur.status[ssf_bit_overrun];
    clr_flags[ssf_ci_framing] = cur.status[ssf_bit_framing];
    clr_flags[ssf_ci_parity] = cur.status[ssf_bit_parity];
    clr_wbits[ssf_ci_tdempty] = reg_wdata[ssf_bit_tdempty];
    clr_wbits[ssf_ci_rxfull] = reg_wdata[ssf_bit_rxfull];
    clr_wbits[ssf_ci_overrun] = reg_wdata[ssf_bit_overrun];
    clr_wbits[ssf_ci_framing] = reg_wdata[ssf_bit_framing];
    clr_wbits[ssf_ci_parity] = reg_wdata[ssf_bit_parity];
    clr_set[ssf_ci_tdempty] = ev_tdempty;
    clr_set[ssf_ci_rxfull] = rx_good;
    // overrun: a word ends while full still set; filtered frames excluded
    clr_set[ssf_ci_overrun] = rx_done & rx_active & rx_keep
      & cur.status[ssf_bit_rxfull];
    // only the first stop bit is presented by the engine in 2-stop mode
    clr_set[ssf_ci_framing] = rx_done & rx_active & rx_keep & ~rx_stop_bit;
    clr_set[ssf_ci_parity] = rx_done & rx_active & rx_parity_fail;
  end

  ssf_arm #(
    .width(ssf_nclr)
  ) u_arm (
    .mclk(mclk),
    .rst_n(rst_n),
    .flags(clr_flags),
    .set_ev(clr_set),
    .rd_ev(st_rd),
    .wr_ev(st_wr),
    .wr_bits(clr_wbits),
    .clear_ok(clr_ok)
  );

  // next-state logic for status, control and read data
  always_comb begin
    next_cur = cur;
    next_cur.store = 1'b0;
    // set wins over clear: set terms are applied after clears
    if (clr_ok[ssf_ci_tdempty]) begin
      next_cur.status[ssf_bit_tdempty] = 1'b0;
      next_cur.status[ssf_bit_txdone] = 1'b0;
    end
    if (clr_ok[ssf_ci_rxfull]) begin
      // rx enable has no effect on this flag
      next_cur.status[ssf_bit_rxfull] = 1'b0;
    end
    if (clr_ok[ssf_ci_overrun]) begin
      next_cur.status[ssf_bit_overrun] = 1'b0;
    end
    if (clr_ok[ssf_ci_framing]) begin
      next_cur.status[ssf_bit_framing] = 1'b0;
    end
    if (clr_ok[ssf_ci_parity]) begin
      next_cur.status[ssf_bit_parity] = 1'b0;
    end
    // written ones are dropped: flags only ever go to 1 by events
    if (ev_tdempty) begin
      next_cur.status[ssf_bit_tdempty] = 1'b1;
    end
    if (ev_txdone) begin
      next_cur.status[ssf_bit_txdone] = 1'b1;
    end
    if (rx_good) begin
      next_cur.status[ssf_bit_rxfull] = 1'b1;
      next_cur.store = 1'b1;
    end
    if (clr_set[ssf_ci_overrun]) begin
      next_cur.status[ssf_bit_overrun] = 1'b1;
    end
    if (clr_set[ssf_ci_framing]) begin
      next_cur.status[ssf_bit_framing] = 1'b1;
    end
    if (clr_set[ssf_ci_parity]) begin
      next_cur.status[ssf_bit_parity] = 1'b1;
    end
    // mpb captured only while receiving; otherwise held
    if (rx_done && rx_active) begin
      next_cur.status[ssf_bit_rxmpb] = rx_mpb_in;
    end
    // transmit mpb is plain read/write
    if (st_wr) begin
      next_cur.status[ssf_bit_txmpb] = reg_wdata[ssf_bit_txmpb];
    end
    if (ct_wr) begin
      next_cur.control = reg_wdata[2:0];
    end
    // filter enable drops itself on an mpb-1 frame, after software writes
    if (rx_done && rx_active && cur.control[ssf_bit_filter] && rx_mpb_in) begin
      next_cur.control[ssf_bit_filter] = 1'b0;
    end
    // read data valid the cycle after the strobe only
    next_cur.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ssf_addr_status) begin
        next_cur.rdata = cur.status;
      end else if (reg_addr == ssf_addr_control) begin
        next_cur.rdata = {5'h00, cur.control};
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur.status <= ssf_status_reset;
      cur.control <= ssf_control_reset;
      cur.rdata <= 8'h00;
      cur.store <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign reg_rdata = cur.rdata;
  assign tx_on_bit = cur.control[ssf_bit_txon];
  assign rx_enable_bit = cur.control[ssf_bit_rxon];
  assign tx_multiproc_bit = cur.status[ssf_bit_txmpb];
  assign rx_store = cur.store;
endmodule : ssf_top

// file: verilog/ssf_pkg.sv
// package: status register layout, reset values and register offsets
package ssf_pkg;
  // register indices on the plain register port
  localparam logic [1:0] ssf_addr_status = 2'h0;
  localparam logic [1:0] ssf_addr_control = 2'h1;
  // status register bit positions
  localparam int ssf_bit_tdempty = 7;
  localparam int ssf_bit_rxfull = 6;
  localparam int ssf_bit_overrun = 5;
  localparam int ssf_bit_framing = 4;
  localparam int ssf_bit_parity = 3;
  localparam int ssf_bit_txdone = 2;
  localparam int ssf_bit_rxmpb = 1;
  localparam int ssf_bit_txmpb = 0;
  // control register bit positions
  localparam int ssf_bit_txon = 0;
  localparam int ssf_bit_rxon = 1;
  localparam int ssf_bit_filter = 2;
  // index of each clearable flag inside the 5-bit clearable group
  localparam int ssf_nclr = 5;
  localparam int ssf_ci_tdempty = 4;
  localparam int ssf_ci_rxfull = 3;
  localparam int ssf_ci_overrun = 2;
  localparam int ssf_ci_framing = 1;
  localparam int ssf_ci_parity = 0;
  // reset values
  localparam logic [7:0] ssf_status_reset = 8'h84;
  localparam logic [2:0] ssf_control_reset = 3'h0;
endpackage : ssf_pkg

// file: verilog/ssf_reset_sync.sv
// reset synchroniser: asynchronous assert, two-flop release
module ssf_reset_sync (
  input wire logic mclk,
  input wire logic rstn,
  output logic rst_sync_n
);
  // two-stage shift register, state as one packed struct
  typedef struct packed {
    logic s1;
    logic s2;
  } ssf_rs_type;
  ssf_rs_type cur;
  ssf_rs_type next_cur;
  // shift a one in after release
  always_comb begin
    next_cur.s1 = 1'b1;
    next_cur.s2 = cur.s1;
  end
  // only constants under asynchronous reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign rst_sync_n = cur.s2;
endmodule : ssf_reset_sync

// file: verilog/ssf_arm.sv
// read-armed clear tracker for the clearable flags
module ssf_arm #(
  parameter int width = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [width-1:0] flags,
  input wire logic [width-1:0] set_ev,
  input wire logic rd_ev,
  input wire logic wr_ev,
  input wire logic [width-1:0] wr_bits,
  output logic [width-1:0] clear_ok
);
  typedef struct packed {
    logic [width-1:0] armed;
  } ssf_arm_type;
  ssf_arm_type cur;
  ssf_arm_type next_cur;
  // per flag: arm on read of 1, disarm on any write or on a fresh set
  generate
    for (genvar i = 0; i < width; i++) begin : g_arm
      // clear only if armed, written 0, and no new event now
      assign clear_ok[i] = cur.armed[i] & wr_ev & ~wr_bits[i] & ~set_ev[i];
    end
  endgenerate
  always_comb begin
    next_cur = cur;
    for (int i = 0; i < width; i++) begin
      if (set_ev[i]) begin
        // a re-set after the read needs a new read
        next_cur.armed[i] = 1'b0;
      end else if (wr_ev) begin
        next_cur.armed[i] = 1'b0;
      end else if (rd_ev && flags[i]) begin
        next_cur.armed[i] = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : ssf_arm

// file: tb/ssf_sva.sv
// checker: port relations of the status flag block
module ssf_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_done,
  input wire logic rx_stop_bit,
  input wire logic rx_parity_fail,
  input wire logic tx_on_bit,
  input wire logic rx_enable_bit,
  input wire logic tx_multiproc_bit,
  input wire logic rx_store
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // status bit zero goes straight to the transmit engine
  property p_tx_multiproc_bit;
    reg_wr && reg_addr == 2'h0 |=> tx_multiproc_bit == $past(reg_wdata[0]);
  endproperty
  a_tx_multiproc_bit: assert property (p_tx_multiproc_bit) else $error("mpb out wrong");
  // enables follow control writes
  property p_ena;
    reg_wr && reg_addr == 2'h1 |=> {rx_enable_bit, tx_on_bit} == $past(reg_wdata[1:0]);
  endproperty
  a_ena: assert property (p_ena) else $error("enables wrong");
  // a store needs a clean frame while receiving
  property p_store;
    rx_store |-> $past(rx_done && rx_enable_bit && rx_stop_bit && !rx_parity_fail);
  endproperty
  a_store: assert property (p_store) else $error("store w/o clean frame");
  property p_frm;
    rx_done && !rx_stop_bit |=> !rx_store;
  endproperty
  a_frm: assert property (p_frm) else $error("store on framing fault");
  property p_par;
    rx_done && rx_parity_fail |=> !rx_store;
  endproperty
  a_par: assert property (p_par) else $error("store on parity fault");
  property p_rxoff;
    rx_done && !rx_enable_bit |=> !rx_store;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("store while rx off");
  // while tx stays off both transmit flags read as one
  property p_txoff;
    reg_rd && reg_addr == 2'h0 && !tx_on_bit && $past(!tx_on_bit) && $past(!reg_wr)
      |=> reg_rdata[7] && reg_rdata[2];
  endproperty
  a_txoff: assert property (p_txoff) else $error("tx flags clear while off");
  // read data only in the cycle after a read strobe
  property p_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("stray read data"); // register port timing
endmodule : ssf_sva
bind ssf_top ssf_sva ssf_sva_i (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_done(rx_done), .rx_stop_bit(rx_stop_bit), .rx_parity_fail(rx_parity_fail),
  .tx_on_bit(tx_on_bit), .rx_enable_bit(rx_enable_bit),
  .tx_multiproc_bit(tx_multiproc_bit), .rx_store(rx_store));

// file: tb/ssf_remote.sv
// partner: remote station whose frames arrive as receive events
module ssf_remote (
  input wire logic mclk,
  output logic rx_done,
  output logic rx_stop_bit,
  output logic rx_parity_fail,
  output logic rx_mpb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_done = 1'b0;
    {rx_stop_bit, rx_parity_fail, rx_mpb_in} = 3'h0;
  end
  // one frame; fields turn to garbage once it has gone
  task automatic frame(input logic s, input logic p, input logic m);
    @(posedge mclk);
    rx_done <= 1'b1;
    {rx_stop_bit, rx_parity_fail, rx_mpb_in} <= {s, p, m};
    @(posedge mclk);
    rx_done <= 1'b0;
    {rx_stop_bit, rx_parity_fail, rx_mpb_in} <= ~{s, p, m};
  endtask : frame
endmodule : ssf_remote

// file: tb/tb.sv
// testbench: status flags driven through register port and frames
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssf_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic tx_load = 1'b0, tx_last_bit = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic rx_done, rx_stop_bit, rx_parity_fail, rx_mpb_in;
  logic tx_on_bit, rx_enable_bit, tx_multiproc_bit, rx_store;
  int fails = 0, n_compared = 0;
  // rows: stop, parity fail, mpb, expected status
  // a clean frame sets the full flag, so the first row reads back with bit 6 up
  logic [10:0] rows [4] = '{{3'h4, 8'hc4}, {3'h5, 8'hc6}, {3'h1, 8'h96},
    {3'h7, 8'h8e}};
  always #2.5 mclk = ~mclk;
  ssf_top ssf_top_i (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_load(tx_load),
    .tx_last_bit(tx_last_bit), .rx_done(rx_done), .rx_stop_bit(rx_stop_bit),
    .rx_parity_fail(rx_parity_fail), .rx_mpb_in(rx_mpb_in), .tx_on_bit(tx_on_bit),
    .rx_enable_bit(rx_enable_bit), .tx_multiproc_bit(tx_multiproc_bit), .rx_store(rx_store));
  ssf_remote ssf_remote_i (.mclk(mclk), .rx_done(rx_done), .rx_stop_bit(rx_stop_bit),
    .rx_parity_fail(rx_parity_fail), .rx_mpb_in(rx_mpb_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read and compare in the one cycle the data stands
  task automatic rc(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
  endtask : rc
  task automatic txp(input logic ld, input logic lb);
    @(posedge mclk);
    {tx_load, tx_last_bit} <= {ld, lb};
    @(posedge mclk);
    {tx_load, tx_last_bit} <= 2'h0;
  endtask : txp
  task automatic give_verdict;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // watchdog: the sequence needs under two hundred cycles
  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rc(ssf_addr_status, ssf_status_reset);
    wr(ssf_addr_control, 8'h02);
    foreach (rows[i]) begin
      ssf_remote_i.frame(rows[i][10], rows[i][9], rows[i][8]);
      // store pulse stands only in the cycle after the frame
      @(negedge mclk);
      chk({7'h00, rx_store}, {7'h00, rows[i][6]});
      rc(ssf_addr_status, rows[i][7:0]);
      wr(ssf_addr_status, 8'h00);
    end
    wr(ssf_addr_status, 8'h79);
    // received mpb is still 1 from the last row frame
    rc(ssf_addr_status, 8'h87);
    chk({7'h00, tx_multiproc_bit}, 8'h01);
    wr(ssf_addr_status, 8'h00);
    // unarmed clear leaves the full flag
    ssf_remote_i.frame(1'b1, 1'b0, 1'b0);
    wr(ssf_addr_status, 8'h00);
    rc(ssf_addr_status, 8'hc4);
    ssf_remote_i.frame(1'b1, 1'b0, 1'b0);
    rc(ssf_addr_status, 8'he4);
    // rx off: frame ignored, flags and mpb held
    wr(ssf_addr_control, 8'h01);
    @(negedge mclk);
    chk({6'h00, rx_enable_bit, tx_on_bit}, 8'h01);
    ssf_remote_i.frame(1'b1, 1'b0, 1'b1);
    @(negedge mclk);
    chk({7'h00, rx_store}, 8'h00);
    rc(ssf_addr_status, 8'he4);
    wr(ssf_addr_status, 8'h00);
    rc(ssf_addr_status, 8'h00);
    txp(1'b1, 1'b0);
    rc(ssf_addr_status, 8'h80);
    wr(ssf_addr_status, 8'h00);
    txp(1'b0, 1'b1);
    rc(ssf_addr_status, 8'h00);
    txp(1'b1, 1'b0);
    txp(1'b0, 1'b1);
    rc(ssf_addr_status, 8'h84);
    // filter drops mpb zero, then self-clears on mpb one
    wr(ssf_addr_control, 8'h06);
    ssf_remote_i.frame(1'b1, 1'b0, 1'b0);
    rc(ssf_addr_status, 8'h84);
    rc(ssf_addr_control, 8'h06);
    ssf_remote_i.frame(1'b1, 1'b0, 1'b1);
    rc(ssf_addr_status, 8'hc6);
    rc(ssf_addr_control, 8'h02);
    // fresh set between read and write survives
    ssf_remote_i.frame(1'b1, 1'b0, 1'b1);
    wr(ssf_addr_status, 8'h00);
    rc(ssf_addr_status, 8'he6);
    wr(2'h2, 8'hff);
    rc(2'h2, 8'h00);
    rc(ssf_addr_status, 8'he6);
    // second reset in mid-run, driven on the rising edge like every input
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    rc(ssf_addr_status, ssf_status_reset);
    rc(ssf_addr_control, 8'h00);
    give_verdict();
  end
endmodule : tb
